// ### hdl/ssrb_defines.svh
/*
 * Constants of the synthesizer serial register bank: addresses, depths,
 * field positions, open-bit masks and reset values.
 * Assumes inclusion by bare name from the package only.
 */
// Functional notes
// [RULE1] decode addresses 0x00 to 0x16, twenty-three locations
// [RULE2] addresses 0x05, 0x06 unused, hold nothing
// [RULE3] transfer length follows each register's own depth
// [RULE4] bit zero is the least significant bit
// [RULE5] buffered values go active on update or profile change
// [RULE6] address step rate sits in bits 55:40
// [RULE7] end address upper bits 39:32, low bits 31:30
// [RULE8] mode 2:0, zero-crossing and no-dwell flags in byte 0
// [RULE9] open bits ignore writes and read zero; code masks on write only, so bits stored before a ram_en change read back
// [RULE10] top register passes one memory word per access
`ifndef SSRB_DEFINES_SVH
`define SSRB_DEFINES_SVH

`define SSRB_ADDR_W        5
`define SSRB_ADDR_CTRL_ONE 5'h00
`define SSRB_ADDR_UNUSED_A 5'h05
`define SSRB_ADDR_UNUSED_B 5'h06
`define SSRB_ADDR_PROF0    5'h0E
`define SSRB_ADDR_PROF7    5'h15
`define SSRB_ADDR_RAM      5'h16
`define SSRB_ADDR_LAST     5'h16
`define SSRB_NUM_LOC       24

`define SSRB_INSTR_READ    7

`define SSRB_DEPTH_DEF     4'h4
`define SSRB_DEPTH_PROF    4'h8
`define SSRB_DEPTH_SHORT   4'h2

`define SSRB_RAM_EN_BIT    31
`define SSRB_STEP_HI       55
`define SSRB_STEP_LO       40
`define SSRB_END_HI        39
`define SSRB_END_LO        32
`define SSRB_END_LSB_HI    31
`define SSRB_END_LSB_LO    30
`define SSRB_START_HI      23
`define SSRB_START_LO      16
`define SSRB_START_LSB_HI  15
`define SSRB_START_LSB_LO  14
`define SSRB_NODWELL_BIT   5
`define SSRB_ZC_BIT        3
`define SSRB_MODE_HI       2
`define SSRB_MODE_LO       0

`define SSRB_MASK_WAVE     64'h00FF_FFFF_C0FF_C02F
`define SSRB_MASK_TONE     64'h3FFF_FFFF_FFFF_FFFF
`define SSRB_RESET_VAL     64'h0000_0000_0000_0000

`endif

// ### hdl/ssrb_pkg.sv
/*
 * Types and shared decoding of the serial register bank.
 * Assumes ssrb_defines.svh is on the include path.
 */
`include "ssrb_defines.svh"

package ssrb_pkg;

	typedef enum logic [1:0] {
		SSRB_INSTR,
		SSRB_DATA,
		SSRB_DONE
	} ssrb_port_t;

	typedef logic [63:0] ssrb_word_t;

	// byte depth of each location; unused and undefined ones still clock
	// four bytes so a stray access cannot desynchronise the port
	function automatic logic [3:0] ssrb_depth(
		input logic [`SSRB_ADDR_W-1:0] addr
	);
		logic [3:0] d;
		d = `SSRB_DEPTH_DEF;
		if (addr == 5'h08)
			d = `SSRB_DEPTH_SHORT;
		else if (addr == 5'h0B || addr == 5'h0C)
			d = `SSRB_DEPTH_PROF;
		else if (addr >= `SSRB_ADDR_PROF0 && addr <= `SSRB_ADDR_PROF7)
			d = `SSRB_DEPTH_PROF;
		return d;
	endfunction

	function automatic ssrb_word_t ssrb_depth_mask(input logic [3:0] d);
		ssrb_word_t m;
		m = 64'hFFFF_FFFF_FFFF_FFFF;
		if (d < 4'h8)
			m = ~(m << {d[2:0], 3'b000});
		return m;
	endfunction

endpackage

// ### hdl/ssrb_serial_port.sv
/*
 * Serial port engine: one instruction byte (read flag, address), then
 * as many data bytes as the addressed location holds, MSB first.
 * Assumes sclk and cs_n synchronous to ref_clk, each sclk phase at least
 * three ref_clk periods long.
 */
`timescale 1ns/1ps
`default_nettype none

module ssrb_serial_port
	import ssrb_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	input  wire logic                    cs_n,
	input  wire logic                    sclk,
	input  wire logic                    sdio_in,
	output logic                         sdio_out,
	output logic                         sdio_oe,
	input  wire ssrb_word_t              rd_data,
	output logic [`SSRB_ADDR_W-1:0]      addr_r,
	output logic                         wr_stb_r,
	output ssrb_word_t                   wr_data_r
);

	ssrb_port_t  state_r;
	logic        sclk_q_r;
	logic        is_read_r;
	logic        load_r;
	logic [6:0]  bit_cnt_r;
	ssrb_word_t  sh_in_r;
	ssrb_word_t  sh_out_r;
	logic [6:0]  frame_bits;
	logic        rise;
	logic        fall;

	assign rise = sclk & ~sclk_q_r;
	assign fall = ~sclk & sclk_q_r;
	assign frame_bits = {ssrb_depth(addr_r), 3'b000};

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			sclk_q_r <= 1'b0;
		else
			sclk_q_r <= sclk;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || cs_n)
		begin
			state_r   <= SSRB_INSTR;
			bit_cnt_r <= 7'h00;
			sh_in_r   <= `SSRB_RESET_VAL;
			is_read_r <= 1'b0;
			load_r    <= 1'b0;
			wr_stb_r  <= 1'b0;
			if (!reset_n)
			begin
				addr_r    <= 5'h00;
				wr_data_r <= `SSRB_RESET_VAL;
			end
		end
		else
		begin
			wr_stb_r <= 1'b0;
			load_r   <= 1'b0;
			if (rise && state_r != SSRB_DONE)
			begin
				sh_in_r   <= {sh_in_r[62:0], sdio_in};
				bit_cnt_r <= bit_cnt_r + 7'h01;
				unique case (state_r)
					SSRB_INSTR:
					begin
						if (bit_cnt_r == 7'h07)
						begin
							is_read_r <= sh_in_r[`SSRB_INSTR_READ-1];
							addr_r    <= {sh_in_r[3:0], sdio_in};
							load_r    <= sh_in_r[`SSRB_INSTR_READ-1];
							bit_cnt_r <= 7'h00;
							state_r   <= SSRB_DATA;
						end
					end
					SSRB_DATA:
					begin
						// value arrives right-aligned, bit 0 last in
						if (bit_cnt_r == frame_bits - 7'h01) // see [RULE3] [RULE4]
						begin
							state_r   <= SSRB_DONE;
							wr_stb_r  <= ~is_read_r;
							wr_data_r <= {sh_in_r[62:0], sdio_in};
						end
					end
					SSRB_DONE:
					begin
					end
				endcase
			end
		end
	end

	// read data leaves on falling edges so the host samples on rising ones
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			sh_out_r <= `SSRB_RESET_VAL;
			sdio_out <= 1'b0;
			sdio_oe  <= 1'b0;
		end
		else
		begin
			if (load_r)
				sh_out_r <= rd_data << {4'h8 - ssrb_depth(addr_r), 3'b000};
			else if (fall && state_r == SSRB_DATA && is_read_r)
			begin
				sdio_out <= sh_out_r[63];
				sh_out_r <= {sh_out_r[62:0], 1'b0};
			end
			sdio_oe <= ~cs_n && is_read_r && state_r == SSRB_DATA;
		end
	end

	frame_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE3]
		$rose(wr_stb_r) |-> $past(bit_cnt_r) == frame_bits - 7'h01)
		else $error("write strobe at wrong bit count");

endmodule

`default_nettype wire

// ### hdl/ssrb_register_bank.sv
/*
 * Serial register bank: buffered registers behind the serial port, the
 * active copies that feed the core, and the waveform memory word path.
 * Assumes io_update and profile_sel synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ssrb_register_bank
	import ssrb_pkg::*;
#(
	parameter int NUM_LOC = `SSRB_NUM_LOC
)
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe,
	input  wire logic        io_update,
	input  wire logic [2:0]  profile_sel,
	output logic [31:0]      control_function_reg_one_r,
	output ssrb_word_t       active_profile_r,
	output logic [31:0]      ram_word_r,
	output logic             ram_word_valid_r
);

	ssrb_word_t                 buf_r [NUM_LOC];
	ssrb_word_t                 act_r [NUM_LOC];
	logic [`SSRB_ADDR_W-1:0]    addr;
	logic                       wr_stb;
	ssrb_word_t                 wr_data;
	ssrb_word_t                 rd_data;
	logic [2:0]                 prof_q_r;
	logic                       prof_chg;
	logic                       upd;
	logic                       ram_en;

	ssrb_serial_port u_port (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.cs_n      (cs_n),
		.sclk      (sclk),
		.sdio_in   (sdio_in),
		.sdio_out  (sdio_out),
		.sdio_oe   (sdio_oe),
		.rd_data   (rd_data),
		.addr_r    (addr),
		.wr_stb_r  (wr_stb),
		.wr_data_r (wr_data)
	);

	// profile layout view follows the active memory enable
	assign ram_en = act_r[`SSRB_ADDR_CTRL_ONE][`SSRB_RAM_EN_BIT];

	function automatic ssrb_word_t ssrb_wmask(
		input logic [`SSRB_ADDR_W-1:0] a,
		input logic                    wave
	);
		ssrb_word_t m;
		m = ssrb_depth_mask(ssrb_depth(a));
		if (a == `SSRB_ADDR_UNUSED_A || a == `SSRB_ADDR_UNUSED_B)
			m = `SSRB_RESET_VAL; // see [RULE2]
		else if (a > `SSRB_ADDR_LAST)
			m = `SSRB_RESET_VAL; // see [RULE1]
		else if (a >= `SSRB_ADDR_PROF0 && a <= `SSRB_ADDR_PROF7)
			m = wave ? `SSRB_MASK_WAVE : `SSRB_MASK_TONE; // see [RULE9]
		return m;
	endfunction

	// undefined addresses read zero rather than alias a real register
	always_comb
	begin
		rd_data = `SSRB_RESET_VAL;
		if (addr <= `SSRB_ADDR_LAST) // see [RULE1]
			rd_data = buf_r[addr];
	end

	assign prof_chg = profile_sel != prof_q_r;
	assign upd      = io_update | prof_chg;

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			prof_q_r <= 3'h0;
		else
			prof_q_r <= profile_sel;
	end

	for (genvar g = 0; g < NUM_LOC; g++)
	begin : g_loc
		localparam logic [`SSRB_ADDR_W-1:0] LA = (`SSRB_ADDR_W)'(g);

		// open bits of the layout in force at the write are dropped on entry, so they read zero until rewritten, even after ram_en changes
		always_ff @(posedge ref_clk)
		begin
			if (!reset_n)
				buf_r[g] <= `SSRB_RESET_VAL;
			else if (wr_stb && addr == LA)
				buf_r[g] <= wr_data & ssrb_wmask(LA, ram_en); // see [RULE9]
		end

		always_ff @(posedge ref_clk)
		begin
			if (!reset_n)
				act_r[g] <= `SSRB_RESET_VAL;
			else if (upd)
				act_r[g] <= buf_r[g]; // see [RULE5]
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			control_function_reg_one_r <= 32'h0000_0000;
			active_profile_r           <= `SSRB_RESET_VAL;
		end
		else
		begin
			control_function_reg_one_r <= act_r[`SSRB_ADDR_CTRL_ONE][31:0];
			active_profile_r <=
				act_r[`SSRB_ADDR_PROF0 + {2'b00, prof_q_r}]; // see [RULE5]
		end
	end

	// memory words bypass the update path: each write access delivers one word
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			ram_word_r       <= 32'h0000_0000;
			ram_word_valid_r <= 1'b0;
		end
		else
		begin
			ram_word_valid_r <= wr_stb && addr == `SSRB_ADDR_RAM; // see [RULE10]
			if (wr_stb && addr == `SSRB_ADDR_RAM)
				ram_word_r <= wr_data[31:0];
		end
	end

	sequence upd_ev;
		io_update || prof_chg;
	endsequence

	sequence prof7_wr;
		wr_stb && addr == `SSRB_ADDR_PROF7;
	endsequence

	upd_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE5]
		upd_ev |=> act_r[`SSRB_ADDR_PROF7] == $past(buf_r[`SSRB_ADDR_PROF7]))
		else $error("active copy missed update");

	hold_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE5]
		!upd |=> $stable(act_r[`SSRB_ADDR_PROF7]))
		else $error("active register changed without update");

	unused_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE2]
		buf_r[`SSRB_ADDR_UNUSED_A] == 64'h0 && buf_r[`SSRB_ADDR_UNUSED_B] == 64'h0)
		else $error("unused location holds data");

	undef_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE1]
		addr > `SSRB_ADDR_LAST |-> rd_data == 64'h0)
		else $error("undefined address returned data");

	step_rate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE6]
		prof7_wr |=> buf_r[`SSRB_ADDR_PROF7][55:40] == $past(wr_data[55:40]))
		else $error("step rate not stored at 55:40");

	end_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE7]
		prof7_wr ##0 ram_en |=>
			buf_r[`SSRB_ADDR_PROF7][39:30] == $past(wr_data[39:30])
			&& buf_r[`SSRB_ADDR_PROF7][29:24] == 6'h00)
		else $error("end address field misplaced");

	mode_byte_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE8]
		prof7_wr ##0 ram_en |=>
			buf_r[`SSRB_ADDR_PROF7][7:0] == ($past(wr_data[7:0]) & 8'h2F))
		else $error("mode byte layout wrong");

	open_bits_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE9]
		prof7_wr ##0 ram_en |=> buf_r[`SSRB_ADDR_PROF7][63:56] == 8'h00)
		else $error("open bits stored");

	ram_word_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [RULE10]
		wr_stb && addr == `SSRB_ADDR_RAM |=>
			ram_word_valid_r && ram_word_r == $past(wr_data[31:0]) ##1 !ram_word_valid_r)
		else $error("memory word not passed once");

endmodule

`default_nettype wire

// ### dv/ssrb_host_model.sv
/*
 * Host controller model for the serial register bank: frames of one
 * instruction byte plus register data, MSB first, sclk mode 0.
 * Assumes ref_clk is the bank's clock; it drives on ref_clk falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module ssrb_host_model
(
	input  wire logic        ref_clk,
	output logic             cs_n,
	output logic             sclk,
	output logic             sdio_in,
	input  wire logic        sdio_out,
	output logic             rd_done,
	output logic [63:0]      rd_word
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdio_in = 1'b0;
		rd_done = 1'b0;
		rd_word = 64'h0;
	end

	// four ref_clk per sclk phase, above the three the port needs
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic xfer(input logic rd, input logic [4:0] a, input int nb,
		input logic [63:0] wd);
		logic [71:0] sh;
		logic [63:0] got;
		got = 64'h0;
		sh = {rd, 2'b00, a, wd << (64 - nb * 8)};
		@(negedge ref_clk);
		cs_n = 1'b0;
		half();
		for (int i = 0; i < 8 + nb * 8; i++)
		begin
			sclk = 1'b0;
			sdio_in = sh[71];
			sh = sh << 1;
			half();
			if (i >= 8)
				got = {got[62:0], sdio_out};
			sclk = 1'b1;
			half();
		end
		sclk = 1'b0;
		half();
		cs_n = 1'b1;
		// released line must not keep looking like data
		sdio_in = ~sdio_in;
		if (rd)
		begin
			rd_word = got;
			rd_done = 1'b1;
			@(negedge ref_clk);
			rd_done = 1'b0;
		end
		half();
	endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
/*
 * Self-checking bench of the serial register bank: host model frames,
 * update strobe and profile select, notes queued and checked by a monitor.
 * Assumes the hdl package and header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ssrb_pkg::*;

	localparam logic [63:0] tone_keep = 64'h3FFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] wave_keep = 64'h00FF_FFFF_C0FF_C02F;

	logic              ref_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              io_update = 1'b0;
	logic [2:0]        profile_sel = 3'h0;
	logic [2:0]        prev_sel = 3'h0;
	wire logic         cs_n;
	wire logic         sclk;
	wire logic         sdio_in;
	logic              sdio_out;
	logic              sdio_oe;
	logic [31:0]       ctl;
	ssrb_word_t        act;
	logic [31:0]       ram_word;
	logic              ram_valid;
	logic [63:0]       rd_q[$];
	logic [63:0]       act_q[$];
	logic [31:0]       ctl_q[$];
	logic [31:0]       ram_q[$];
	logic [4:0]        bad[3] = '{5'h05, 5'h06, 5'h17};
	logic              tr1 = 1'b0;
	logic              tr2 = 1'b0;
	logic [63:0]       v;
	logic [63:0]       w;
	logic [31:0]       r;
	int                errors = 0;
	int                checked = 0;
	int                cycles = 0;

	ssrb_register_bank dut (
		.ref_clk                    (ref_clk),
		.reset_n                    (reset_n),
		.cs_n                       (cs_n),
		.sclk                       (sclk),
		.sdio_in                    (sdio_in),
		.sdio_out                   (sdio_out),
		.sdio_oe                    (sdio_oe),
		.io_update                  (io_update),
		.profile_sel                (profile_sel),
		.control_function_reg_one_r (ctl),
		.active_profile_r           (act),
		.ram_word_r                 (ram_word),
		.ram_word_valid_r           (ram_valid)
	);

	ssrb_host_model host (
		.ref_clk  (ref_clk),
		.cs_n     (cs_n),
		.sclk     (sclk),
		.sdio_in  (sdio_in),
		.sdio_out (sdio_out),
		.rd_done  (),
		.rd_word  ()
	);

	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [63:0] e,
		input logic [63:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rd(input logic [4:0] a, input int nb, input logic [63:0] e);
		rd_q.push_back(e);
		host.xfer(1'b1, a, nb, 64'h0);
	endtask

	task automatic upd(input logic [63:0] ep, input logic [31:0] ec);
		act_q.push_back(ep);
		ctl_q.push_back(ec);
		@(negedge ref_clk);
		io_update = 1'b1;
		@(negedge ref_clk);
		io_update = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask

	// the copy to active shows two edges after its trigger
	always @(posedge ref_clk)
	begin
		#1;
		if (tr2)
		begin
			cmp("active_profile_r", act_q.pop_front(), act);
			cmp("control_reg", {32'h0, ctl_q.pop_front()}, {32'h0, ctl});
		end
		tr2 = tr1;
		tr1 = io_update | (profile_sel != prev_sel);
		prev_sel = profile_sel;
		if (host.rd_done === 1'b1)
			cmp("read data", rd_q.pop_front(), host.rd_word);
		if (ram_valid === 1'b1)
			cmp("ram_word_r", {32'h0, ram_q.pop_front()}, {32'h0, ram_word});
		// device must not drive the data line outside a frame
		if (cs_n === 1'b1)
			cmp("sdio_oe", 64'h0, {63'h0, sdio_oe});
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	initial
	begin
		void'($urandom(32'h4DD7));
		repeat (2) @(negedge ref_clk);
		reset_n = 1'b1;
		rd(5'h15, 8, 64'h0);
		v = {$urandom, $urandom};
		host.xfer(1'b0, 5'h15, 8, v);
		rd(5'h15, 8, v & tone_keep);
		cmp("active held", 64'h0, act);
		act_q.push_back(v & tone_keep);
		ctl_q.push_back(32'h0);
		profile_sel = 3'h7;
		repeat (4) @(negedge ref_clk);
		host.xfer(1'b0, 5'h00, 4, 64'h8000_0000);
		rd(5'h00, 4, 64'h8000_0000);
		upd(v & tone_keep, 32'h8000_0000);
		w = {$urandom, $urandom};
		host.xfer(1'b0, 5'h15, 8, w);
		rd(5'h15, 8, w & wave_keep);
		upd(w & wave_keep, 32'h8000_0000);
		act_q.push_back(64'h0);
		ctl_q.push_back(32'h8000_0000);
		profile_sel = 3'h0;
		repeat (4) @(negedge ref_clk);
		foreach (bad[i])
		begin
			host.xfer(1'b0, bad[i], 4, {32'h0, $urandom});
			rd(bad[i], 4, 64'h0);
		end
		// back-to-back words, no update strobe needed
		repeat (3)
		begin
			r = $urandom;
			ram_q.push_back(r);
			host.xfer(1'b0, 5'h16, 4, {32'h0, r});
		end
		repeat (20) @(negedge ref_clk);
		tally_and_finish();
	end
endmodule

`default_nettype wire
